//--- common/igp_pkg.sv
// Shared constants and types of the inertial and receiver payload builder
package igp_pkg;
  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int IMU_RATE_HZ = 800;
  localparam int SAMPLE_CYC = CLK_HZ / IMU_RATE_HZ;
  localparam int GNSS_RATE_HZ = 5;
  // Fixed point step format and float conversion
  localparam int DV_FRAC = 16;
  localparam logic [7:0] FLT_EXP_BASE = 8'(127 - DV_FRAC);
  localparam int UTC_YEAR_BASE = 2000;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IMU_SEL = 8'h04;
  localparam logic [7:0] REG_GNSS_SEL = 8'h08;
  localparam logic [7:0] REG_DIV = 8'h0c;
  localparam logic [7:0] REG_POLL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_SAT = 8'h18;
  // Control, poll and reset values
  localparam int CTRL_IMU_EN = 0;
  localparam int CTRL_GNSS_EN = 1;
  localparam int CTRL_ON_UPD = 2;
  localparam int POLL_IMU = 0;
  localparam int POLL_GNSS = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [31:0] DIV_RST = 32'h0000_0000;
  // Inertial group selection bits
  localparam int F_DVEL = 7;
  localparam int F_MAG = 8;
  localparam int F_ACC = 9;
  localparam int F_RATE = 10;
  localparam int F_SAT = 11;
  localparam logic [15:0] IMU_SEL_MASK = 16'h0f80;
  // Receiver group selection bits
  localparam int F_UTC = 0;
  localparam int F_TOW = 1;
  localparam int F_WEEK = 2;
  localparam int F_SATS = 3;
  localparam int F_FIX = 4;
  localparam int F_LLA = 5;
  localparam int F_ECEF = 6;
  localparam logic [15:0] GNSS_SEL_MASK = 16'h007f;
  // Field lengths in bytes
  localparam logic [4:0] LEN_VEC3F = 5'd12;
  localparam logic [4:0] LEN_U16 = 5'd2;
  localparam logic [4:0] LEN_U64 = 5'd8;
  localparam logic [4:0] LEN_U8 = 5'd1;
  localparam logic [4:0] LEN_VEC3D = 5'd24;
  // Fix codes
  localparam logic [7:0] FIX_NONE = 8'h00;
  localparam logic [7:0] FIX_3D = 8'h03;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOAD = 2'b01, ST_SEND = 2'b11} igp_state_e;
  typedef enum logic {GRP_INERT = 1'b0, GRP_RECV = 1'b1} igp_grp_e;
  typedef logic [2:0][31:0] igp_vec3f_t;
  typedef logic [2:0][63:0] igp_vec3d_t;

  typedef struct packed {
    logic pres_clipped;
    logic rate_z_clipped;
    logic rate_y_clipped;
    logic rate_x_clipped;
    logic force_z_clipped;
    logic force_y_clipped;
    logic force_x_clipped;
    logic field_z_clipped;
    logic field_y_clipped;
    logic field_x_clipped;
  } igp_sat_s;

  typedef struct packed {
    logic [15:0] msec;
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
    logic signed [7:0] year_offset;
  } igp_utc_s;

  typedef struct packed {
    igp_vec3d_t earth_centred_position;
    igp_vec3d_t geodetic_position;
    logic [7:0] fix;
    logic [7:0] tracked_satellite_count;
    logic [15:0] week;
    logic [63:0] tow_ns;
    igp_utc_s utc;
  } igp_gnss_s;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } igp_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } igp_axil_rsp_s;
endpackage

//--- logic/igp_payload_builder.sv
// Payload builder for the inertial tail group and the receiver group
// How it works
// - Sum velocity steps on each inertial sample tick
// - Clear velocity sum when it is emitted
// - Velocity increment: three floats, offsets 0/4/8
// - Compensated field: three floats, bytes 0-11
// - Compensated acceleration: three floats, bytes 0-11
// - Compensated turn rate: three floats, bytes 0-11
// - Saturation word: ten flags, bits 10-15 zero
// - Receiver selection bits 0-6 name fields
// - Receiver values change only on receiver update
// - Update-rate mode: packet on each receiver update
// - Otherwise receiver packets follow the sample divisor
// - Time field: year offset, date, hour, milliseconds
// - Time of week: 64-bit nanoseconds, bytes 0-7
// - Week field: two-byte unsigned week number
// - Satellite count: one unsigned byte
// - Fix byte coded 0 to 3
// - Geodetic position: three doubles, 24 bytes
// - Earth-centred position: three doubles, offsets 0/8/16
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module igp_payload_builder #(
  parameter int SAMPLE_PERIOD_CYC = igp_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register bus
  input wire igp_pkg::igp_axil_req_s axil_req,
  output igp_pkg::igp_axil_rsp_s axil_rsp,
  // Compensated sensor data
  input wire igp_pkg::igp_vec3f_t velocity_increment_step,
  input wire igp_pkg::igp_vec3f_t compensated_field,
  input wire igp_pkg::igp_vec3f_t compensated_accel,
  input wire igp_pkg::igp_vec3f_t compensated_turn_rate,
  input wire igp_pkg::igp_sat_s saturation_flags,
  // Receiver solution
  input wire logic gnss_update,
  input wire igp_pkg::igp_gnss_s gnss_in,
  // Payload byte stream
  output logic [7:0] out_data,
  output logic out_valid,
  output logic out_last,
  output igp_pkg::igp_grp_e out_group,
  input wire logic out_ready
);
  import igp_pkg::*;

  function automatic logic [31:0] to_float(input logic [31:0] v);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0] msb;
    mag = v[31] ? 32'(-v) : v;
    msb = 5'd0;
    for (int i = 0; i < 32; i++)
    begin
      if (mag[i])
      begin
        msb = 5'(i);
      end
    end
    norm = mag << (5'd31 - msb);
    // Truncation, not rounding: keeps the converter one level deep
    return (mag == 32'h0000_0000) ? 32'h0000_0000 :
           {v[31], FLT_EXP_BASE + {3'h0, msb}, norm[30:8]};
  endfunction

  function automatic logic [4:0] first_sel(input logic [15:0] sel, input logic [4:0] from);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--)
    begin
      if (sel[i] && (5'(i) >= from))
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] field_len(input igp_grp_e grp, input logic [3:0] f);
    logic [4:0] n;
    n = 5'd0;
    if (grp == GRP_INERT)
    begin
      case (f)
        4'(F_DVEL), 4'(F_MAG), 4'(F_ACC), 4'(F_RATE): n = LEN_VEC3F;
        4'(F_SAT): n = LEN_U16;
        default: n = 5'd0;
      endcase
    end
    else
    begin
      case (f)
        4'(F_UTC), 4'(F_TOW): n = LEN_U64;
        4'(F_WEEK): n = LEN_U16;
        4'(F_SATS), 4'(F_FIX): n = LEN_U8;
        4'(F_LLA), 4'(F_ECEF): n = LEN_VEC3D;
        default: n = 5'd0;
      endcase
    end
    return n;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Sample tick
  logic [31:0] smp_cnt_q;
  logic tick_q;
  wire smp_wrap = smp_cnt_q == 32'(SAMPLE_PERIOD_CYC - 1);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      smp_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      smp_cnt_q <= smp_wrap ? 32'h0000_0000 : smp_cnt_q + 32'h0000_0001;
      tick_q <= smp_wrap;
    end
  end

  // Register bus slave
  logic aw_free_q, w_free_q, ar_free_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] ctrl_q, div_q;
  logic [15:0] imu_sel_q, gnss_sel_q;
  logic imu_pend_q, gnss_pend_q;
  igp_state_e state_q;
  igp_gnss_s gnss_rec_q;

  wire aw_hs = axil_req.awvalid && aw_free_q;
  wire w_hs = axil_req.wvalid && w_free_q;
  wire ar_hs = axil_req.arvalid && ar_free_q;
  wire wr_go = !aw_free_q && !w_free_q && !bvalid_q;
  wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
  wire [7:0] ra = {axil_req.araddr[7:2], 2'b00};
  wire wr_ctrl = wr_go && (wa == REG_CTRL);
  wire wr_isel = wr_go && (wa == REG_IMU_SEL);
  wire wr_gsel = wr_go && (wa == REG_GNSS_SEL);
  wire wr_div = wr_go && (wa == REG_DIV);
  wire wr_poll = wr_go && (wa == REG_POLL);
  wire wr_ok = wr_ctrl || wr_isel || wr_gsel || wr_div || wr_poll;
  wire [31:0] poll_bits = merge(32'h0000_0000, w_data_q, w_strb_q);
  wire poll_imu = wr_poll && poll_bits[POLL_IMU];
  wire poll_gnss = wr_poll && poll_bits[POLL_GNSS];
  wire [31:0] wr_merged_ctrl = merge(ctrl_q, w_data_q, w_strb_q);
  wire [31:0] wr_merged_isel = merge({16'h0000, imu_sel_q}, w_data_q, w_strb_q);
  wire [31:0] wr_merged_gsel = merge({16'h0000, gnss_sel_q}, w_data_q, w_strb_q);
  wire [31:0] status_word = {8'h00, gnss_rec_q.fix, gnss_rec_q.tracked_satellite_count,
                             5'h00, gnss_pend_q, imu_pend_q, state_q != ST_IDLE};
  wire rd_ok = (ra == REG_CTRL) || (ra == REG_IMU_SEL) || (ra == REG_GNSS_SEL) ||
               (ra == REG_DIV) || (ra == REG_POLL) || (ra == REG_STATUS) || (ra == REG_SAT);
  wire [31:0] rd_word = (ra == REG_CTRL) ? ctrl_q :
                        (ra == REG_IMU_SEL) ? {16'h0000, imu_sel_q} :
                        (ra == REG_GNSS_SEL) ? {16'h0000, gnss_sel_q} :
                        (ra == REG_DIV) ? div_q :
                        (ra == REG_STATUS) ? status_word :
                        (ra == REG_SAT) ? {22'h000000, saturation_flags} : 32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aw_free_q <= 1'b1;
      w_free_q <= 1'b1;
      ar_free_q <= 1'b1;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RST;
      div_q <= DIV_RST;
      imu_sel_q <= SEL_RST;
      gnss_sel_q <= SEL_RST;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_free_q <= 1'b0;
        aw_addr_q <= axil_req.awaddr;
      end
      if (w_hs)
      begin
        w_free_q <= 1'b0;
        w_data_q <= axil_req.wdata;
        w_strb_q <= axil_req.wstrb;
      end
      if (wr_go)
      begin
        aw_free_q <= 1'b1;
        w_free_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && axil_req.bready)
      begin
        bvalid_q <= 1'b0;
      end
      if (wr_ctrl)
      begin
        ctrl_q <= wr_merged_ctrl & 32'h0000_0007;
      end
      if (wr_isel)
      begin
        imu_sel_q <= wr_merged_isel[15:0];
      end
      if (wr_gsel)
      begin
        gnss_sel_q <= wr_merged_gsel[15:0];
      end
      if (wr_div)
      begin
        div_q <= merge(div_q, w_data_q, w_strb_q);
      end
      if (ar_hs)
      begin
        ar_free_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && axil_req.rready)
      begin
        rvalid_q <= 1'b0;
        ar_free_q <= 1'b1;
      end
    end
  end

  assign axil_rsp = '{awready: aw_free_q, wready: w_free_q, bresp: bresp_q, bvalid: bvalid_q,
                      arready: ar_free_q, rdata: rdata_q, rresp: rresp_q, rvalid: rvalid_q};

  // Output dividers on the sample tick; zero divisor stops that divider, polls and update mode still send
  logic [15:0] imu_div_cnt_q, gnss_div_cnt_q;
  wire imu_div_hit = tick_q && (div_q[15:0] != 16'h0000) &&
                     (imu_div_cnt_q == div_q[15:0] - 16'h0001);
  wire gnss_div_hit = tick_q && (div_q[31:16] != 16'h0000) &&
                      (gnss_div_cnt_q == div_q[31:16] - 16'h0001);
  wire on_upd = ctrl_q[CTRL_ON_UPD];
  wire gnss_trig = (on_upd ? gnss_update : gnss_div_hit) || poll_gnss;
  wire imu_trig = imu_div_hit || poll_imu;

  // Packet scheduling; inertial group has priority
  wire idle = state_q == ST_IDLE;
  wire take_imu = idle && imu_pend_q;
  wire take_gnss = idle && !imu_pend_q && gnss_pend_q;
  wire [15:0] imu_sel_eff = imu_sel_q & IMU_SEL_MASK;
  wire [15:0] gnss_sel_eff = gnss_sel_q & GNSS_SEL_MASK;
  wire [15:0] start_sel = take_imu ? imu_sel_eff : gnss_sel_eff;
  wire [4:0] start_f = first_sel(start_sel, 5'd0);
  wire dv_clear = take_imu && imu_sel_eff[F_DVEL];

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      imu_div_cnt_q <= 16'h0000;
      gnss_div_cnt_q <= 16'h0000;
      imu_pend_q <= 1'b0;
      gnss_pend_q <= 1'b0;
    end
    else
    begin
      if (tick_q)
      begin
        imu_div_cnt_q <= imu_div_hit || (div_q[15:0] == 16'h0000) ? 16'h0000 :
                         imu_div_cnt_q + 16'h0001;
        gnss_div_cnt_q <= gnss_div_hit || (div_q[31:16] == 16'h0000) ? 16'h0000 :
                          gnss_div_cnt_q + 16'h0001;
      end
      // A new trigger in the take cycle is kept, not lost
      imu_pend_q <= (imu_pend_q && !take_imu) || (imu_trig && ctrl_q[CTRL_IMU_EN]);
      gnss_pend_q <= (gnss_pend_q && !take_gnss) || (gnss_trig && ctrl_q[CTRL_GNSS_EN]);
    end
  end

  // Velocity sum in signed fixed point
  igp_vec3f_t acc_q;
  // A net, since each axis is driven by its own assignment
  wire igp_vec3f_t acc_d;
  for (genvar i = 0; i < 3; i++)
  begin : g_acc
    wire [31:0] base = dv_clear ? 32'h0000_0000 : acc_q[i];
    assign acc_d[i] = tick_q ? base + velocity_increment_step[i] : base;
  end

  // Receiver record is held between receiver updates
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      acc_q <= '0;
      gnss_rec_q <= '0;
    end
    else
    begin
      acc_q <= acc_d;
      if (gnss_update)
      begin
        gnss_rec_q <= gnss_in;
      end
    end
  end

  // Snapshots and serialiser
  igp_vec3f_t dv_snap_q, mag_snap_q, acc_snap_q, rate_snap_q;
  logic [15:0] sat_snap_q, sel_snap_q;
  igp_gnss_s gnss_snap_q;
  igp_grp_e grp_q;
  logic [3:0] fidx_q;
  logic [4:0] bidx_q;
  logic [7:0] out_data_q;
  logic out_valid_q, out_last_q;
  logic [191:0] fvec;

  always_comb
  begin
    fvec = '0;
    if (grp_q == GRP_INERT)
    begin
      case (fidx_q)
        4'(F_DVEL): fvec = 192'(dv_snap_q);
        4'(F_MAG): fvec = 192'(mag_snap_q);
        4'(F_ACC): fvec = 192'(acc_snap_q);
        4'(F_RATE): fvec = 192'(rate_snap_q);
        4'(F_SAT): fvec = 192'(sat_snap_q);
        default: fvec = '0;
      endcase
    end
    else
    begin
      case (fidx_q)
        4'(F_UTC): fvec = 192'(gnss_snap_q.utc);
        4'(F_TOW): fvec = 192'(gnss_snap_q.tow_ns);
        4'(F_WEEK): fvec = 192'(gnss_snap_q.week);
        4'(F_SATS): fvec = 192'(gnss_snap_q.tracked_satellite_count);
        4'(F_FIX): fvec = 192'(gnss_snap_q.fix);
        4'(F_LLA): fvec = gnss_snap_q.geodetic_position;
        4'(F_ECEF): fvec = gnss_snap_q.earth_centred_position;
        default: fvec = '0;
      endcase
    end
  end

  // Byte of the pointed field, lowest byte first
  wire [7:0] cur_byte = fvec[{bidx_q, 3'b000} +: 8];
  wire [4:0] cur_len = field_len(grp_q, fidx_q);
  wire [4:0] nb = bidx_q + 5'd1;
  wire in_field = nb < cur_len;
  wire [4:0] nf = first_sel(sel_snap_q, 5'(fidx_q) + 5'd1);
  wire succ_end = !in_field && nf[4];
  wire [3:0] succ_f = in_field ? fidx_q : nf[3:0];
  wire [4:0] succ_b = in_field ? nb : 5'd0;
  wire out_hs = out_valid_q && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      grp_q <= GRP_INERT;
      fidx_q <= 4'h0;
      bidx_q <= 5'd0;
      sel_snap_q <= 16'h0000;
      out_data_q <= 8'h00;
      out_valid_q <= 1'b0;
      out_last_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if ((take_imu || take_gnss) && !start_f[4])
          begin
            state_q <= ST_LOAD;
            grp_q <= take_imu ? GRP_INERT : GRP_RECV;
            sel_snap_q <= start_sel;
            fidx_q <= start_f[3:0];
            bidx_q <= 5'd0;
          end
        end
        ST_LOAD:
        begin
          state_q <= ST_SEND;
          out_valid_q <= 1'b1;
          out_data_q <= cur_byte;
          out_last_q <= succ_end;
          fidx_q <= succ_f;
          bidx_q <= succ_b;
        end
        ST_SEND:
        begin
          if (out_hs && out_last_q)
          begin
            state_q <= ST_IDLE;
            out_valid_q <= 1'b0;
            out_last_q <= 1'b0;
          end
          else if (out_hs)
          begin
            out_data_q <= cur_byte;
            out_last_q <= succ_end;
            fidx_q <= succ_f;
            bidx_q <= succ_b;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          out_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // Snapshot data registers need no reset
  always_ff @(posedge sys_clk)
  begin
    if (take_imu)
    begin
      for (int i = 0; i < 3; i++)
      begin
        dv_snap_q[i] <= to_float(acc_q[i]);
      end
      mag_snap_q <= compensated_field;
      acc_snap_q <= compensated_accel;
      rate_snap_q <= compensated_turn_rate;
      sat_snap_q <= {6'h00, saturation_flags};
    end
    if (take_gnss)
    begin
      gnss_snap_q <= gnss_rec_q;
    end
  end

  assign out_data = out_data_q;
  assign out_valid = out_valid_q;
  assign out_last = out_last_q;
  assign out_group = grp_q;

  // Checks
  sequence s_stall;
    out_valid_q && !out_ready;
  endsequence
  sequence s_utc_load;
    (state_q == ST_LOAD) && (grp_q == GRP_RECV) && (fidx_q == 4'(F_UTC)) && (bidx_q == 5'd0);
  endsequence

  property p_tick;
    @(posedge sys_clk) disable iff (sys_rst)
    tick_q |-> $past(smp_cnt_q) == 32'(SAMPLE_PERIOD_CYC - 1);
  endproperty
  a_tick: assert property (p_tick)
    else $error("sample tick off period");

  property p_acc_step;
    @(posedge sys_clk) disable iff (sys_rst)
    (tick_q && !dv_clear) |=> acc_q[0] == $past(acc_q[0]) + $past(velocity_increment_step[0]);
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("velocity sum missed a step");

  property p_acc_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    (dv_clear && !tick_q) |=> acc_q == '0;
  endproperty
  a_acc_clear: assert property (p_acc_clear)
    else $error("velocity sum not cleared on emit");

  property p_sat_resv;
    @(posedge sys_clk) disable iff (sys_rst)
    take_imu |=> (sat_snap_q[15:10] == 6'h00) && (sat_snap_q[9:0] == $past(saturation_flags));
  endproperty
  a_sat_resv: assert property (p_sat_resv)
    else $error("saturation word wrong");

  property p_gnss_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !gnss_update |=> $stable(gnss_rec_q);
  endproperty
  a_gnss_hold: assert property (p_gnss_hold)
    else $error("receiver record changed without update");

  property p_on_update;
    @(posedge sys_clk) disable iff (sys_rst)
    (gnss_update && on_upd && ctrl_q[CTRL_GNSS_EN]) |=> gnss_pend_q;
  endproperty
  a_on_update: assert property (p_on_update)
    else $error("receiver update did not request a packet");

  property p_div_rate;
    @(posedge sys_clk) disable iff (sys_rst)
    ($rose(gnss_pend_q) && !$past(on_upd)) |-> $past(tick_q) || $past(poll_gnss);
  endproperty
  a_div_rate: assert property (p_div_rate)
    else $error("receiver packet requested off the divisor");

  property p_utc_first;
    @(posedge sys_clk) disable iff (sys_rst)
    s_utc_load |=> out_data_q == gnss_snap_q.utc.year_offset;
  endproperty
  a_utc_first: assert property (p_utc_first)
    else $error("time field does not open with year");

  property p_order;
    @(posedge sys_clk) disable iff (sys_rst)
    ((state_q == ST_SEND) && out_hs && !out_last_q && !succ_end) |=>
      (fidx_q > $past(fidx_q)) || ((fidx_q == $past(fidx_q)) && (bidx_q == $past(bidx_q) + 5'd1));
  endproperty
  a_order: assert property (p_order)
    else $error("payload bytes out of order");

  property p_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    s_stall |=> out_valid_q && $stable(out_data_q) && $stable(out_last_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stream byte changed while stalled");
endmodule

//--- verif/igp_host_model.sv
// Host model: takes payload bytes with random stalls and keeps them
`timescale 1ns/10ps
module igp_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Payload stream
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  input wire logic out_last,
  input wire igp_pkg::igp_grp_e out_group,
  output logic out_ready = 1'b0
);
  import igp_pkg::*;
  logic [7:0] rx[$];
  igp_grp_e grp[$];
  int seed = 32'h415f1943;
  // Stalls about a quarter of cycles so held bytes are exercised
  always @(posedge sys_clk)
  begin
    if (out_valid && out_ready)
    begin
      rx.push_back(out_data);
      if (out_last)
        grp.push_back(out_group);
    end
    out_ready <= !sys_rst && ($random(seed) % 4 != 0);
  end
endmodule

//--- verif/imu_gnss_payload_builder_tb_top.sv
// Testbench of the payload builder against a byte-level reference
`timescale 1ns/10ps
module imu_gnss_payload_builder_tb_top;
  import igp_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  igp_axil_req_s axil_req = '0;
  igp_axil_rsp_s axil_rsp;
  igp_vec3f_t vstep = '0;
  igp_vec3f_t fld = '0;
  igp_vec3f_t acc = '0;
  igp_vec3f_t rate = '0;
  igp_sat_s sat = '0;
  logic gnss_update = 1'b0;
  igp_gnss_s gnss_in = '0;
  igp_gnss_s g_exp;
  logic [7:0] out_data;
  logic out_valid;
  logic out_last;
  logic out_ready;
  igp_grp_e out_group;
  int err_count = 0;
  int n_tests = 0;
  int seed = 32'h415f1943;
  logic [7:0] exp_q[$];
  igp_grp_e exp_g[$];
  logic [1:0] r;
  logic [31:0] d;

  always #2.5 sys_clk = ~sys_clk;

  igp_payload_builder #(.SAMPLE_PERIOD_CYC(20)) igp_payload_builder_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .velocity_increment_step(vstep), .compensated_field(fld), .compensated_accel(acc),
    .compensated_turn_rate(rate), .saturation_flags(sat), .gnss_update(gnss_update),
    .gnss_in(gnss_in), .out_data(out_data), .out_valid(out_valid), .out_last(out_last),
    .out_group(out_group), .out_ready(out_ready));

  igp_host_model igp_host_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .out_data(out_data), .out_valid(out_valid), .out_last(out_last),
    .out_group(out_group), .out_ready(out_ready));

  // Cycle of each packet start, for the divisor spacing
  int cyc = 0;
  int rise_at[$];
  logic v_q = 1'b0;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    v_q <= out_valid;
    if (out_valid && !v_q)
      rise_at.push_back(cyc);
  end

  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  // Starts one edge late so ready or valid is never set twice in one step
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic b;
    b = 1'b0;
    @(posedge sys_clk);
    axil_req.awaddr <= a;
    axil_req.awvalid <= 1'b1;
    axil_req.wdata <= v;
    axil_req.wstrb <= 4'hf;
    axil_req.wvalid <= 1'b1;
    axil_req.bready <= 1'b1;
    while (!b)
    begin
      @(posedge sys_clk);
      if (axil_req.awvalid && axil_rsp.awready)
        axil_req.awvalid <= 1'b0;
      if (axil_req.wvalid && axil_rsp.wready)
        axil_req.wvalid <= 1'b0;
      if (axil_rsp.bvalid)
      begin
        r = axil_rsp.bresp;
        axil_req.bready <= 1'b0;
        b = 1'b1;
      end
    end
  endtask

  task rd(input logic [7:0] a);
    logic b;
    b = 1'b0;
    @(posedge sys_clk);
    axil_req.araddr <= a;
    axil_req.arvalid <= 1'b1;
    axil_req.rready <= 1'b1;
    while (!b)
    begin
      @(posedge sys_clk);
      if (axil_req.arvalid && axil_rsp.arready)
        axil_req.arvalid <= 1'b0;
      if (axil_rsp.rvalid)
      begin
        d = axil_rsp.rdata;
        r = axil_rsp.rresp;
        axil_req.rready <= 1'b0;
        b = 1'b1;
      end
    end
  endtask

  task push(input logic [543:0] v, input int n, input igp_grp_e g);
    for (int i = 0; i < n; i++)
      exp_q.push_back(v[8*i +: 8]);
    exp_g.push_back(g);
  endtask

  // Receiver record latched on the pulse, then the live input moves on
  task gupd();
    for (int i = 0; i < 17; i++)
      g_exp[32*i +: 32] = $random(seed);
    gnss_in <= g_exp;
    gnss_update <= 1'b1;
    @(posedge sys_clk);
    gnss_update <= 1'b0;
    gnss_in <= ~g_exp;
  endtask

  task pkt(input string name);
    int t;
    t = 0;
    while (igp_host_model_inst.grp.size() < exp_g.size() && t < 3000)
    begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 3000)
    begin
      err_count++;
      $display("CHECK FAILED %s packets expected %0d seen %0d", name, exp_g.size(),
               igp_host_model_inst.grp.size());
    end
    chk({name, " length"}, exp_q.size(), igp_host_model_inst.rx.size());
    foreach (exp_q[i])
      chk({name, " byte"}, exp_q[i], igp_host_model_inst.rx[i]);
    foreach (exp_g[i])
      chk({name, " group"}, exp_g[i], igp_host_model_inst.grp[i]);
    exp_q.delete();
    exp_g.delete();
    igp_host_model_inst.rx.delete();
    igp_host_model_inst.grp.delete();
    $display("test %s done", name);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    fld <= {$random(seed), $random(seed), $random(seed)};
    acc <= {$random(seed), $random(seed), $random(seed)};
    rate <= {$random(seed), $random(seed), $random(seed)};
    sat <= 10'($random(seed));
    rd(REG_CTRL);
    chk("ctrl reset", CTRL_RST, d);
    rd(REG_DIV);
    chk("div reset", DIV_RST, d);
    rd(8'h1c);
    chk("unmapped read resp", RESP_SLVERR, r);
    wr(8'h1c, 32'hffff_ffff);
    chk("unmapped write resp", RESP_SLVERR, r);
    rd(REG_SAT);
    chk("saturation", {22'h0, sat}, d);
    $display("test registers done");
    wr(REG_IMU_SEL, 32'h0000_0f00);
    wr(REG_GNSS_SEL, 32'h0000_007f);
    wr(REG_CTRL, 32'h3);
    gupd();
    wr(REG_POLL, 32'h3);
    push({240'h0, 6'h0, sat, rate, acc, fld}, 38, GRP_INERT);
    push(g_exp, 68, GRP_RECV);
    pkt("poll");
    wr(REG_CTRL, 32'h6);
    gupd();
    push(g_exp, 68, GRP_RECV);
    pkt("update");
    rd(REG_STATUS);
    chk("status", {8'h00, g_exp.fix, g_exp.tracked_satellite_count, 8'h00}, d);
    wr(REG_CTRL, 32'h1);
    wr(REG_IMU_SEL, 32'h0000_0080);
    vstep <= 96'h0001_0000;
    repeat (200) @(posedge sys_clk);
    vstep <= '0;
    wr(REG_POLL, 32'h1);
    push(96'h4120_0000, 12, GRP_INERT);
    pkt("sum");
    wr(REG_POLL, 32'h1);
    push(544'h0, 12, GRP_INERT);
    pkt("cleared");
    wr(REG_CTRL, 32'h2);
    rise_at.delete();
    wr(REG_DIV, 32'h0008_0000);
    push(g_exp, 68, GRP_RECV);
    push(g_exp, 68, GRP_RECV);
    pkt("divisor");
    chk("divisor spacing", 32'd160, rise_at[1] - rise_at[0]);
    print_verdict();
  end

  initial
  begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule
